// ===== wdt_pkg.sv
// Watchdog timer register block: shared constants and types.
// Assumes a 12-bit byte address on a plain strobe port and 32-bit data.
`default_nettype none

package wdt_pkg;

  //////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] OFS_LOAD     = 12'h000;
  localparam logic [11:0] OFS_COUNT    = 12'h004;
  localparam logic [11:0] OFS_CONTROL  = 12'h008;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h00c;
  localparam logic [11:0] OFS_RAW_STAT = 12'h010;
  localparam logic [11:0] OFS_MSK_STAT = 12'h014;
  localparam logic [11:0] OFS_GUARD    = 12'hc00;

  //////////////////////////////////////////////////////////////////////
  // Reset values, keys and field positions
  localparam logic [31:0] LOAD_RESET   = 32'hffffffff;
  localparam logic [31:0] COUNT_RESET  = 32'hffffffff;
  localparam logic [31:0] COUNT_ZERO   = 32'h00000000;
  localparam logic [31:0] COUNT_STEP   = 32'h00000001;
  localparam logic [31:0] GUARD_KEY    = 32'h1acce551;
  localparam logic [31:0] READ_ZERO    = 32'h00000000;
  localparam int          IRQ_EN_BIT   = 0;
  localparam int          RST_EN_BIT   = 1;
  localparam int          FLAG_BIT     = 0;

  //////////////////////////////////////////////////////////////////////
  // Slow tick and system clock rates, nominal
  localparam int          SLOW_CLK_HZ  = 32768;
  localparam int          SYS_CLK_HZ   = 40000000;

  //////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic resetEn;
    logic irqEn;
  } wdt_ctrl_t;

  localparam wdt_ctrl_t CTRL_RESET = '{resetEn: 1'b0, irqEn: 1'b0};

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } wdt_bus_req_t;

  // Address decode used for every register
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction

endpackage

`default_nettype wire

// ===== wdt_slow_tick.sv
// Slow clock sampler: turns the asynchronous slow clock pin into a
// one-cycle tick on each filtered rising edge.
// Assumes the slow clock is far slower than clk (32.768 kHz vs 40 MHz).
`timescale 1ns/1ps
`default_nettype none

module wdt_slow_tick (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic slowClk,
  output var  logic slowTick
);

  logic syncA_ff;
  logic syncB_ff;
  logic syncC_ff;
  logic level_ff;
  logic tick_ff;
  logic agree;
  logic nxt_level;

  //////////////////////////////////////////////////////////////////////
  // Three-stage sampler; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncA_ff <= 1'b0;
      syncB_ff <= 1'b0;
      syncC_ff <= 1'b0;
    end else begin
      syncA_ff <= slowClk;
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
    end
  end

  // A change counts only once stages two and three agree
  assign agree     = syncB_ff == syncC_ff;
  assign nxt_level = agree ? syncC_ff : level_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_ff <= 1'b0;
      tick_ff  <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      tick_ff  <= nxt_level & ~level_ff;
    end
  end

  assign slowTick = tick_ff;

endmodule // wdt_slow_tick

`default_nettype wire

// ===== wdt_timer_regs.sv
// Watchdog timer: 32-bit down-counter on a slow tick, its register set
// on a plain strobe port, an interrupt and a sticky system reset request.
// Assumes one 40 MHz clock, a synchronous reset and a bus master that
// never asserts read and write together.
//
// Notes on behaviour
// - Writing load restarts the count from the new value; load resets to ones.
// - Count register reads the live counter; writes to it do nothing.
// - Control bit 0 enables the interrupt.
// - Control bit 1 enables the reset output.
// - Any write to irq clear drops the interrupt and reloads; reads give zero.
// - Raw status bit 0 shows the unmasked interrupt; read only.
// - Masked status bit 0 shows interrupt gated by enable; read only.
// - Guard register reads 0 when writes allowed, 1 when blocked.
// - Writing the key to guard unblocks writes; any other value blocks.
// - Counter is 32 bits and steps down at the slow tick rate.
// - At zero the counter raises the interrupt and reloads from load.
// - Zero again with interrupt pending asserts reset when reset enabled.
// - Disabling the interrupt halts counting; enabling restarts from load.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module wdt_timer_regs (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        slowClk,
  input  wire logic [11:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output var  logic [31:0] regRdata,
  output var  logic        wdtIrq,
  output var  logic        wdtResetReq
);

  //////////////////////////////////////////////////////////////////////
  // Storage
  logic [31:0]       load_ff;
  logic [31:0]       count_ff;
  wdt_pkg::wdt_ctrl_t ctrl_ff;
  logic              rawIrq_ff;
  logic              irqOut_ff;
  logic              resetReq_ff;
  logic              locked_ff;
  logic [31:0]       rdata_ff;

  //////////////////////////////////////////////////////////////////////
  // Next values
  logic [31:0]       nxt_load;
  logic [31:0]       nxt_count;
  wdt_pkg::wdt_ctrl_t nxt_ctrl;
  logic              nxt_rawIrq;
  logic              nxt_irqOut;
  logic              nxt_resetReq;
  logic              nxt_locked;
  logic [31:0]       nxt_rdata;

  //////////////////////////////////////////////////////////////////////
  // Decode and event wires
  logic              slowTick;
  wire               selLoad;
  wire               selCount;
  wire               selCtrl;
  wire               selClear;
  wire               selRaw;
  wire               selMasked;
  wire               selGuard;
  wire               wrOpen;
  wire               wrLoad;
  wire               wrCtrl;
  wire               wrClear;
  wire               wrGuard;
  wire               newIrqEn;
  wire               newRstEn;
  wire               enRise;
  wire               counting;
  wire               atZero;
  wire               zeroEvent;
  wire               overrun;
  wire               maskedFlag;
  wire [31:0]        countDown;
  wire [31:0]        ctrlWord;
  wire [31:0]        rawWord;
  wire [31:0]        maskedWord;
  wire [31:0]        guardWord;

  //////////////////////////////////////////////////////////////////////
  // Slow tick source
  wdt_slow_tick u_tick (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .slowClk  (slowClk),
    .slowTick (slowTick)
  );

  //////////////////////////////////////////////////////////////////////
  // Address decode
  assign selLoad   = wdt_pkg::reg_hit(regAddr, wdt_pkg::OFS_LOAD);
  assign selCount  = wdt_pkg::reg_hit(regAddr, wdt_pkg::OFS_COUNT);
  assign selCtrl   = wdt_pkg::reg_hit(regAddr, wdt_pkg::OFS_CONTROL);
  assign selClear  = wdt_pkg::reg_hit(regAddr, wdt_pkg::OFS_IRQ_CLR);
  assign selRaw    = wdt_pkg::reg_hit(regAddr, wdt_pkg::OFS_RAW_STAT);
  assign selMasked = wdt_pkg::reg_hit(regAddr, wdt_pkg::OFS_MSK_STAT);
  assign selGuard  = wdt_pkg::reg_hit(regAddr, wdt_pkg::OFS_GUARD);

  //////////////////////////////////////////////////////////////////////
  // Write qualification
  // Guard is always writable so a locked block can be reopened
  assign wrOpen  = ~locked_ff;
  assign wrLoad  = regWrite & selLoad & wrOpen;
  assign wrCtrl  = regWrite & selCtrl & wrOpen;
  assign wrClear = regWrite & selClear & wrOpen;
  assign wrGuard = regWrite & selGuard;
  // Writes to count and status offsets decode to nothing

  //////////////////////////////////////////////////////////////////////
  // Control register
  assign newIrqEn = regWdata[wdt_pkg::IRQ_EN_BIT];
  assign newRstEn = regWdata[wdt_pkg::RST_EN_BIT];

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wrCtrl) begin
      nxt_ctrl.irqEn   = newIrqEn;
      nxt_ctrl.resetEn = newRstEn;
    end
  end

  // Only the off-to-on step reloads; rewriting 1 keeps the count
  assign enRise = wrCtrl & newIrqEn & ~ctrl_ff.irqEn;

  //////////////////////////////////////////////////////////////////////
  // Load register
  assign nxt_load = wrLoad ? regWdata : load_ff;

  //////////////////////////////////////////////////////////////////////
  // Down-counter
  // Counter halts whenever the interrupt is disabled
  assign counting  = ctrl_ff.irqEn;
  assign atZero    = count_ff == wdt_pkg::COUNT_ZERO;
  // Zero is held for one tick, giving an interval of load+1 ticks
  assign zeroEvent = slowTick & counting & atZero;
  assign countDown = count_ff - wdt_pkg::COUNT_STEP;

  always_comb begin
    nxt_count = count_ff;
    if (wrLoad) begin
      nxt_count = regWdata;
    end else if (enRise) begin
      nxt_count = load_ff;
    end else if (wrClear) begin
      nxt_count = load_ff;
    end else if (zeroEvent) begin
      nxt_count = load_ff;
    end else if (slowTick & counting) begin
      nxt_count = countDown;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt and reset
  // A zero event in the clear cycle still sets the flag
  assign nxt_rawIrq = zeroEvent | (rawIrq_ff & ~wrClear);

  // A clear in the same cycle counts as served in time
  assign overrun = zeroEvent & rawIrq_ff & ~wrClear;

  // Reset request holds until the system reset takes effect
  assign nxt_resetReq = resetReq_ff | (overrun & ctrl_ff.resetEn);

  assign nxt_irqOut = nxt_rawIrq & nxt_ctrl.irqEn;

  //////////////////////////////////////////////////////////////////////
  // Write guard
  assign nxt_locked = wrGuard ? (regWdata != wdt_pkg::GUARD_KEY) : locked_ff;

  //////////////////////////////////////////////////////////////////////
  // Read path
  assign maskedFlag = rawIrq_ff & ctrl_ff.irqEn;
  // Reserved bits above the defined fields read as zero
  assign ctrlWord   = 32'(ctrl_ff);
  assign rawWord    = 32'(rawIrq_ff) << wdt_pkg::FLAG_BIT;
  assign maskedWord = 32'(maskedFlag) << wdt_pkg::FLAG_BIT;
  assign guardWord  = 32'(locked_ff);

  always_comb begin
    nxt_rdata = wdt_pkg::READ_ZERO;
    if (regRead) begin
      if (selLoad) begin
        nxt_rdata = load_ff;
      end else if (selCount) begin
        nxt_rdata = count_ff;
      end else if (selCtrl) begin
        nxt_rdata = ctrlWord;
      end else if (selClear) begin
        nxt_rdata = wdt_pkg::READ_ZERO;
      end else if (selRaw) begin
        nxt_rdata = rawWord;
      end else if (selMasked) begin
        nxt_rdata = maskedWord;
      end else if (selGuard) begin
        nxt_rdata = guardWord;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      load_ff  <= wdt_pkg::LOAD_RESET;
      count_ff <= wdt_pkg::COUNT_RESET;
    end else begin
      load_ff  <= nxt_load;
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff   <= wdt_pkg::CTRL_RESET;
      locked_ff <= 1'b0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      locked_ff <= nxt_locked;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rawIrq_ff   <= 1'b0;
      irqOut_ff   <= 1'b0;
      resetReq_ff <= 1'b0;
    end else begin
      rawIrq_ff   <= nxt_rawIrq;
      irqOut_ff   <= nxt_irqOut;
      resetReq_ff <= nxt_resetReq;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= wdt_pkg::READ_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs
  assign regRdata    = rdata_ff;
  assign wdtIrq      = irqOut_ff;
  assign wdtResetReq = resetReq_ff;

endmodule // wdt_timer_regs

`default_nettype wire

// ===== wdt_timer_regs_asserts.sv
// Port-level assertions for the watchdog register block.
// Assumes it is bound to wdt_timer_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module wdt_timer_regs_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        slowClk,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        wdtIrq,
  input wire logic        wdtResetReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (!regRead |=> regRdata == 32'h0)
    else $error("read data not zero outside a read");
  AST_CLR_RD: assert property (regRead && regAddr == wdt_pkg::OFS_IRQ_CLR |=> regRdata == 32'h0)
    else $error("irq clear read not zero");
  AST_CTRL_RD: assert property (regRead && regAddr == wdt_pkg::OFS_CONTROL |=> regRdata[31:2] == 30'h0)
    else $error("control upper bits not zero");
  AST_RAW_RD: assert property (regRead && regAddr == wdt_pkg::OFS_RAW_STAT |=> regRdata[31:1] == 31'h0)
    else $error("raw status upper bits not zero");
  AST_MSK_RD: assert property (regRead && regAddr == wdt_pkg::OFS_MSK_STAT
    |=> regRdata == {31'h0, $past(wdtIrq)})
    else $error("masked status differs from irq line");
  AST_GUARD_RD: assert property (regRead && regAddr == wdt_pkg::OFS_GUARD |=> regRdata[31:1] == 31'h0)
    else $error("guard read not 0 or 1");
  // Only a system reset may drop the request
  AST_RST_HOLD: assert property (wdtResetReq |=> wdtResetReq)
    else $error("reset request dropped");
  AST_RST_CAUSE: assert property ($rose(wdtResetReq) |-> $past(wdtIrq))
    else $error("reset request without pending irq");
  // Two write-free cycles; a clear drops wdtIrq on the very edge that samples its strobe
  AST_IRQ_HOLD: assert property (wdtIrq && !regWrite && !$past(regWrite) |=> wdtIrq)
    else $error("irq dropped without a write");
endmodule // wdt_timer_regs_asserts

bind wdt_timer_regs wdt_timer_regs_asserts u_chk (
  .clk(clk), .sys_rst(sys_rst), .slowClk(slowClk), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .wdtIrq(wdtIrq), .wdtResetReq(wdtResetReq));
`default_nettype wire

// ===== wdt_timer_regs_bench.sv
// Self-checking bench for the watchdog register block.
// Assumes package and design compiled first; the bench makes slowClk itself.
`timescale 1ns/1ps
`default_nettype none

module wdt_timer_regs_bench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        slowClk = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdata;
  logic        wdtIrq;
  logic        wdtResetReq;
  int          err_count = 0;
  int          num_checks = 0;

  always #12.5 clk = ~clk;

  wdt_timer_regs u_dut (.clk(clk), .sys_rst(sys_rst), .slowClk(slowClk), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .wdtIrq(wdtIrq), .wdtResetReq(wdtResetReq));

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask

  // Slow clock stands low between ticks; tick lands about 4 clk after the rise
  task automatic tick(input int n);
    repeat (n) begin
      slowClk <= 1'b1;
      repeat (12) @(posedge clk);
      slowClk <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask

  task automatic rst_dut();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  initial begin
    #200000;
    err_count++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_dut();
    rd(wdt_pkg::OFS_LOAD, wdt_pkg::LOAD_RESET);
    rd(wdt_pkg::OFS_COUNT, wdt_pkg::COUNT_RESET);
    rd(wdt_pkg::OFS_CONTROL, 32'h0);
    rd(wdt_pkg::OFS_IRQ_CLR, 32'h0);
    rd(wdt_pkg::OFS_RAW_STAT, 32'h0);
    rd(wdt_pkg::OFS_MSK_STAT, 32'h0);
    rd(wdt_pkg::OFS_GUARD, 32'h0);
    rd(12'h018, 32'h0);
    $display("test reset values done");
    wr(wdt_pkg::OFS_LOAD, 32'h5);
    rd(wdt_pkg::OFS_COUNT, 32'h5);
    wr(wdt_pkg::OFS_CONTROL, 32'h1);
    tick(2);
    rd(wdt_pkg::OFS_COUNT, 32'h3);
    wr(wdt_pkg::OFS_COUNT, 32'h77);
    rd(wdt_pkg::OFS_COUNT, 32'h3);
    wr(wdt_pkg::OFS_CONTROL, 32'h0);
    tick(1);
    rd(wdt_pkg::OFS_COUNT, 32'h3);
    wr(wdt_pkg::OFS_CONTROL, 32'h1);
    rd(wdt_pkg::OFS_COUNT, 32'h5);
    $display("test counting done");
    wr(wdt_pkg::OFS_LOAD, 32'h1);
    wr(wdt_pkg::OFS_CONTROL, 32'h3);
    tick(2);
    rd(wdt_pkg::OFS_RAW_STAT, 32'h1);
    rd(wdt_pkg::OFS_COUNT, 32'h1);
    rd(wdt_pkg::OFS_MSK_STAT, 32'h1);
    chk({31'h0, wdtIrq}, 32'h1);
    wr(wdt_pkg::OFS_CONTROL, 32'h2);
    rd(wdt_pkg::OFS_MSK_STAT, 32'h0);
    chk({31'h0, wdtIrq}, 32'h0);
    rd(wdt_pkg::OFS_RAW_STAT, 32'h1);
    wr(wdt_pkg::OFS_CONTROL, 32'h3);
    wr(wdt_pkg::OFS_IRQ_CLR, 32'hdeadbeef);
    rd(wdt_pkg::OFS_IRQ_CLR, 32'h0);
    rd(wdt_pkg::OFS_RAW_STAT, 32'h0);
    rd(wdt_pkg::OFS_COUNT, 32'h1);
    tick(2);
    rd(wdt_pkg::OFS_RAW_STAT, 32'h1);
    chk({31'h0, wdtResetReq}, 32'h0);
    tick(2);
    chk({31'h0, wdtResetReq}, 32'h1);
    $display("test irq and reset done");
    rst_dut();
    wr(wdt_pkg::OFS_LOAD, 32'h1);
    wr(wdt_pkg::OFS_CONTROL, 32'h1);
    tick(4);
    rd(wdt_pkg::OFS_RAW_STAT, 32'h1);
    chk({31'h0, wdtResetReq}, 32'h0);
    wr(wdt_pkg::OFS_GUARD, 32'h1acce550);
    rd(wdt_pkg::OFS_GUARD, 32'h1);
    wr(wdt_pkg::OFS_LOAD, 32'h9);
    rd(wdt_pkg::OFS_LOAD, 32'h1);
    wr(wdt_pkg::OFS_CONTROL, 32'h0);
    rd(wdt_pkg::OFS_CONTROL, 32'h1);
    wr(wdt_pkg::OFS_IRQ_CLR, 32'h0);
    rd(wdt_pkg::OFS_RAW_STAT, 32'h1);
    wr(wdt_pkg::OFS_RAW_STAT, 32'h0);
    rd(wdt_pkg::OFS_RAW_STAT, 32'h1);
    wr(wdt_pkg::OFS_GUARD, wdt_pkg::GUARD_KEY);
    rd(wdt_pkg::OFS_GUARD, 32'h0);
    wr(wdt_pkg::OFS_LOAD, 32'h9);
    rd(wdt_pkg::OFS_COUNT, 32'h9);
    $display("test write guard done");
    complete_run();
  end
endmodule // wdt_timer_regs_bench
`default_nettype wire
